// File: rtl/crp_pkg.sv
package crp_pkg;

    // ****************************************************************
    // instruction codes (octal, 24-bit words)
    // ****************************************************************
    localparam logic [23:0] CRP_OP_RDR_READY_TEST   = 24'o04012006;
    localparam logic [23:0] CRP_OP_FIRST_COL_TEST   = 24'o04014006;
    localparam logic [23:0] CRP_OP_RDR_EOF_TEST     = 24'o04011006;
    localparam logic [23:0] CRP_OP_PUN_BUF_TEST     = 24'o04012046;
    localparam logic [23:0] CRP_OP_PUN_READY_TEST   = 24'o04014046;
    localparam logic [23:0] CRP_OP_READ_TEXT        = 24'o00202606;
    localparam logic [23:0] CRP_OP_READ_RAW         = 24'o00203606;
    localparam logic [23:0] CRP_OP_SKIP_REST        = 24'o00212006;
    localparam logic [23:0] CRP_OP_PUNCH_TEXT       = 24'o00202646;
    localparam logic [23:0] CRP_OP_PUNCH_RAW        = 24'o00203646;
    // every instruction decode compare ignores bits above the low 21 (channel prefix)
    localparam logic [23:0] CRP_OP_MASK             = 24'o07777777;

    // ****************************************************************
    // card geometry
    // ****************************************************************
    localparam int          CRP_COLUMNS             = 80;
    localparam int          CRP_ROWS                = 12;
    localparam logic [7:0]  CRP_TEXT_CHARS          = 8'd80;
    localparam logic [7:0]  CRP_RAW_CHARS           = 8'd160;
    localparam logic [3:0]  CRP_LAST_PASS           = 4'd11;
    localparam logic [1:0]  CRP_UNIT                = 2'd1;
    localparam logic [1:0]  CRP_CHARS_PER_WORD      = 2'd3;

    // ****************************************************************
    // timing at 200 MHz
    // ****************************************************************
    localparam int          CRP_CLK_KHZ             = 200000;
    localparam int          CRP_FEED_US             = 85000;
    localparam int          CRP_IMMINENT_US         = 1200;
    localparam int          CRP_FEED_CYC            = CRP_FEED_US * (CRP_CLK_KHZ / 1000);
    localparam int          CRP_IMMINENT_CYC        = CRP_IMMINENT_US * (CRP_CLK_KHZ / 1000);

    typedef enum logic [1:0] {
        CRP_RD_IDLE = 2'b00,
        CRP_RD_FEED = 2'b01,
        CRP_RD_XFER = 2'b10,
        CRP_RD_SKIP = 2'b11
    } crp_rd_state_t;

endpackage

// File: rtl/crp_row_scan.sv
`timescale 1ns/100ps
// one punch row: decides per column whether the hole is punched in this row
module crp_row_scan #(
    parameter int COLS = 80
) (
    // image and row
    input  wire logic [COLS*12-1:0] i_image,
    input  wire logic [3:0]         i_row,
    // result
    output logic      [COLS-1:0]    o_holes
);
    genvar c;
    generate
        for (c = 0; c < COLS; c++) begin : g_col
            assign o_holes[c] = i_image[c*12 + i_row];
        end
    endgenerate
endmodule

// File: rtl/crp_coupler.sv
`timescale 1ns/100ps
module crp_coupler
    import crp_pkg::*;
#(
    parameter int FEED_CYC     = crp_pkg::CRP_FEED_CYC,
    parameter int IMMINENT_CYC = crp_pkg::CRP_IMMINENT_CYC
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // instruction issue
    input  wire logic        i_instr_valid,
    input  wire logic [23:0] i_instr,
    output logic             o_skip_valid,
    output logic             o_skip,
    // reader mechanism
    input  wire logic        i_rdr_hopper_empty,
    input  wire logic        i_rdr_stacker_full,
    input  wire logic        i_rdr_start_btn,
    input  wire logic        i_rdr_eof_switch,
    input  wire logic        i_rdr_last_card,
    input  wire logic        i_rdr_col_valid,
    input  wire logic [11:0] i_rdr_col,
    input  wire logic        i_rdr_col_ok,
    input  wire logic        i_rdr_read_check,
    input  wire logic        i_rdr_feed_check,
    output logic             o_rdr_feed,
    // channel, reader side
    input  wire logic        i_ch_count_zero,
    output logic             o_ch_char_valid,
    output logic [5:0]       o_ch_char,
    output logic             o_ch_validity_err,
    output logic             o_ch_end_record,
    output logic             o_ch_count_zero_int,
    output logic             o_rdr_connected,
    // punch mechanism
    input  wire logic        i_pun_magazine_empty,
    input  wire logic        i_pun_stacker_full,
    input  wire logic        i_pun_start_btn,
    input  wire logic        i_pun_row_strobe,
    output logic             o_pun_ready,
    output logic             o_pun_feed,
    output logic             o_pun_row_valid,
    output logic [3:0]       o_pun_row,
    output logic [79:0]      o_pun_holes,
    output logic             o_pun_cycle_done,
    // channel, punch side
    input  wire logic        i_ch_out_valid,
    input  wire logic [5:0]  i_ch_out_char
);
    import crp_pkg::*;

    // ****************************************************************
    // instruction decode
    // ****************************************************************
    wire logic [23:0] op = i_instr & CRP_OP_MASK;
    wire logic is_rrt  = i_instr_valid && op == (CRP_OP_RDR_READY_TEST & CRP_OP_MASK);
    wire logic is_fct  = i_instr_valid && op == (CRP_OP_FIRST_COL_TEST & CRP_OP_MASK);
    wire logic is_eoft = i_instr_valid && op == (CRP_OP_RDR_EOF_TEST & CRP_OP_MASK);
    wire logic is_pbt  = i_instr_valid && op == (CRP_OP_PUN_BUF_TEST & CRP_OP_MASK);
    wire logic is_prt  = i_instr_valid && op == (CRP_OP_PUN_READY_TEST & CRP_OP_MASK);
    wire logic is_rdt  = i_instr_valid && op == (CRP_OP_READ_TEXT & CRP_OP_MASK);
    wire logic is_rdr  = i_instr_valid && op == (CRP_OP_READ_RAW & CRP_OP_MASK);
    wire logic is_skr  = i_instr_valid && op == (CRP_OP_SKIP_REST & CRP_OP_MASK);
    wire logic is_pnt  = i_instr_valid && op == (CRP_OP_PUNCH_TEXT & CRP_OP_MASK);
    wire logic is_pnr  = i_instr_valid && op == (CRP_OP_PUNCH_RAW & CRP_OP_MASK);
    wire logic is_test = is_rrt | is_fct | is_eoft | is_pbt | is_prt;

    // ****************************************************************
    // reader ready and end-of-file
    // ****************************************************************
    logic rdr_ready_reg;
    logic eof_reg;
    wire logic rdr_fault = i_rdr_hopper_empty | i_rdr_stacker_full;
    wire logic rdr_ready_next = rdr_fault ? 1'b0 :
                                (i_rdr_start_btn ? 1'b1 : rdr_ready_reg);
    wire logic eof_next = (!i_rdr_eof_switch) ? 1'b0 :
                          (i_rdr_last_card ? 1'b1 :
                          (!i_rdr_hopper_empty ? 1'b0 : eof_reg));

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdr_ready_reg <= 1'b0;
            eof_reg       <= 1'b0;
        end else begin
            rdr_ready_reg <= rdr_ready_next;
            eof_reg       <= eof_next;
        end
    end

    // ****************************************************************
    // reader sequencer
    // ****************************************************************
    crp_rd_state_t rd_state_reg, rd_state_next;
    logic [31:0]   feed_cnt_reg, feed_cnt_next;
    logic          raw_mode_reg;
    logic          half_reg;
    logic [5:0]    low_char_reg;
    logic [7:0]    char_cnt_reg;
    wire  logic    start_read = (is_rdt | is_rdr) && rd_state_reg == CRP_RD_IDLE;
    wire  logic    col_take   = rd_state_reg == CRP_RD_XFER && i_rdr_col_valid && !half_reg;
    wire  logic    rec_end    = i_rdr_read_check | i_rdr_feed_check | i_ch_count_zero;
    wire  logic    rd_done    = (rd_state_reg == CRP_RD_XFER || rd_state_reg == CRP_RD_SKIP)
                                && rec_end;
    wire  logic [7:0] lim     = raw_mode_reg ? CRP_RAW_CHARS : CRP_TEXT_CHARS;
    wire  logic    at_lim     = char_cnt_reg >= lim;
    // first column imminent once the remaining feed time drops below the margin
    wire  logic    imminent   = rd_state_reg == CRP_RD_FEED
                                && feed_cnt_reg < 32'(IMMINENT_CYC);

    always_comb begin
        rd_state_next = rd_state_reg;
        feed_cnt_next = feed_cnt_reg;
        case (rd_state_reg)
            CRP_RD_IDLE: begin
                if (start_read) begin
                    rd_state_next = CRP_RD_FEED;
                    feed_cnt_next = 32'(FEED_CYC);
                end
            end
            CRP_RD_FEED: begin
                if (feed_cnt_reg == 32'd0) begin
                    rd_state_next = CRP_RD_XFER;
                end else begin
                    feed_cnt_next = feed_cnt_reg - 32'd1;
                end
            end
            CRP_RD_XFER: begin
                if (rec_end) begin
                    rd_state_next = CRP_RD_IDLE;
                end else if (is_skr) begin
                    rd_state_next = CRP_RD_SKIP;
                end
            end
            CRP_RD_SKIP: begin
                if (rec_end) begin
                    rd_state_next = CRP_RD_IDLE;
                end
            end
            default: rd_state_next = CRP_RD_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_state_reg <= CRP_RD_IDLE;
            feed_cnt_reg <= 32'd0;
        end else begin
            rd_state_reg <= rd_state_next;
            feed_cnt_reg <= feed_cnt_next;
        end
    end

    // ****************************************************************
    // column to character conversion
    // ****************************************************************
    // text code: zone rows 12,11,0 give two bits, digit rows give four
    logic [5:0] text_char;
    logic       text_ok;
    always_comb begin
        text_char = 6'h00;
        text_ok   = i_rdr_col_ok;
        case (i_rdr_col[11:9])
            3'b000:  text_char[5:4] = 2'b00;
            3'b100:  text_char[5:4] = 2'b11;
            3'b010:  text_char[5:4] = 2'b10;
            3'b001:  text_char[5:4] = 2'b01;
            default: text_ok = 1'b0;
        endcase
        case (i_rdr_col[8:0])
            9'h000:  text_char[3:0] = 4'h0;
            9'h100:  text_char[3:0] = 4'h1;
            9'h080:  text_char[3:0] = 4'h2;
            9'h040:  text_char[3:0] = 4'h3;
            9'h020:  text_char[3:0] = 4'h4;
            9'h010:  text_char[3:0] = 4'h5;
            9'h008:  text_char[3:0] = 4'h6;
            9'h004:  text_char[3:0] = 4'h7;
            9'h002:  text_char[3:0] = 4'h8;
            9'h001:  text_char[3:0] = 4'h9;
            default: text_ok = 1'b0;
        endcase
    end

    // ****************************************************************
    // channel transfer
    // ****************************************************************
    wire logic xfer_on = rd_state_reg == CRP_RD_XFER && !is_skr && !rec_end;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            raw_mode_reg        <= 1'b0;
            half_reg            <= 1'b0;
            low_char_reg        <= 6'h00;
            char_cnt_reg        <= 8'd0;
            o_ch_char_valid     <= 1'b0;
            o_ch_char           <= 6'h00;
            o_ch_validity_err   <= 1'b0;
        end else begin
            o_ch_char_valid   <= 1'b0;
            o_ch_validity_err <= 1'b0;
            if (start_read) begin
                raw_mode_reg <= is_rdr;
                char_cnt_reg <= 8'd0;
                half_reg     <= 1'b0;
            end else if (xfer_on && half_reg) begin
                o_ch_char_valid <= 1'b1;
                o_ch_char       <= low_char_reg;
                half_reg        <= 1'b0;
                char_cnt_reg    <= char_cnt_reg + 8'd1;
            end else if (xfer_on && col_take && !at_lim) begin
                o_ch_char_valid <= 1'b1;
                char_cnt_reg    <= char_cnt_reg + 8'd1;
                if (raw_mode_reg) begin
                    o_ch_char    <= i_rdr_col[11:6];
                    low_char_reg <= i_rdr_col[5:0];
                    half_reg     <= 1'b1;
                end else begin
                    o_ch_char         <= text_char;
                    o_ch_validity_err <= !text_ok;
                end
            end
        end
    end

    // ****************************************************************
    // reader status outputs
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdr_feed          <= 1'b0;
            o_ch_end_record     <= 1'b0;
            o_ch_count_zero_int <= 1'b0;
            o_rdr_connected     <= 1'b0;
        end else begin
            o_rdr_feed          <= start_read;
            o_ch_end_record     <= rd_state_reg == CRP_RD_SKIP && rec_end;
            o_ch_count_zero_int <= rd_state_reg == CRP_RD_XFER && i_ch_count_zero;
            o_rdr_connected     <= rd_state_next != CRP_RD_IDLE;
        end
    end

    // ****************************************************************
    // punch ready and image buffer
    // ****************************************************************
    logic        pun_ready_reg;
    logic        pun_busy_reg;
    logic        pun_raw_reg;
    logic [3:0]  pass_reg;
    logic [7:0]  pchar_reg;
    logic        buf_full_reg;
    logic [CRP_COLUMNS*12-1:0] image_reg;
    wire  logic  pun_fault = i_pun_magazine_empty | i_pun_stacker_full;
    wire  logic  pun_ready_next = pun_fault ? 1'b0 :
                                  (i_pun_start_btn ? 1'b1 : pun_ready_reg);
    wire  logic  pun_cmd  = is_pnt | is_pnr;
    wire  logic  pun_go   = pun_cmd && pun_ready_reg && !buf_full_reg;
    wire  logic [7:0] plim = pun_raw_reg ? CRP_RAW_CHARS : CRP_TEXT_CHARS;
    wire  logic  img_last = pchar_reg == plim - 8'd1;
    wire  logic  img_take = pun_busy_reg && i_ch_out_valid && !buf_full_reg;
    // column and half of the incoming character
    wire  logic [6:0] pcol = pun_raw_reg ? pchar_reg[7:1] : pchar_reg[6:0];
    wire  logic [11:0] text_rows = {i_ch_out_char[5:4] == 2'b11, i_ch_out_char[5:4] == 2'b10,
                                    i_ch_out_char[5:4] == 2'b01,
                                    i_ch_out_char[3:0] == 4'h1, i_ch_out_char[3:0] == 4'h2,
                                    i_ch_out_char[3:0] == 4'h3, i_ch_out_char[3:0] == 4'h4,
                                    i_ch_out_char[3:0] == 4'h5, i_ch_out_char[3:0] == 4'h6,
                                    i_ch_out_char[3:0] == 4'h7, i_ch_out_char[3:0] == 4'h8,
                                    i_ch_out_char[3:0] == 4'h9};
    // bit 11 is row 12, bit 0 is row 9
    wire  logic [3:0] row_idx = 4'(CRP_ROWS - 1) - pass_reg;
    wire  logic [CRP_COLUMNS-1:0] holes;

    crp_row_scan #(
        .COLS    (CRP_COLUMNS)
    ) u_scan (
        .i_image (image_reg),
        .i_row   (row_idx),
        .o_holes (holes)
    );

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pun_ready_reg <= 1'b0;
            pun_busy_reg  <= 1'b0;
            pun_raw_reg   <= 1'b0;
            pass_reg      <= 4'd0;
            pchar_reg     <= 8'd0;
            buf_full_reg  <= 1'b0;
            image_reg     <= '0;
        end else begin
            pun_ready_reg <= pun_ready_next;
            if (pun_go) begin
                pun_busy_reg <= 1'b1;
                pun_raw_reg  <= is_pnr;
                pchar_reg    <= 8'd0;
                image_reg    <= '0;
            end else if (img_take) begin
                if (pun_raw_reg && pchar_reg[0])
                    image_reg[pcol*12 +: 6] <= i_ch_out_char;
                else if (pun_raw_reg)
                    image_reg[pcol*12+6 +: 6] <= i_ch_out_char;
                else
                    image_reg[pcol*12 +: 12] <= text_rows;
                pchar_reg <= pchar_reg + 8'd1;
                if (img_last) begin
                    buf_full_reg <= 1'b1;
                    pun_busy_reg <= 1'b0;
                end
            end else if (buf_full_reg && i_pun_row_strobe) begin
                buf_full_reg <= 1'b0;
                pass_reg <= (pass_reg == CRP_LAST_PASS) ? 4'd0 : pass_reg + 4'd1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pun_ready      <= 1'b0;
            o_pun_feed       <= 1'b0;
            o_pun_row_valid  <= 1'b0;
            o_pun_row        <= 4'd0;
            o_pun_holes      <= '0;
            o_pun_cycle_done <= 1'b0;
        end else begin
            o_pun_ready      <= pun_ready_reg;
            o_pun_feed       <= pun_go && pass_reg == 4'd0;
            o_pun_row_valid  <= buf_full_reg;
            o_pun_row        <= row_idx;
            o_pun_holes      <= holes;
            o_pun_cycle_done <= buf_full_reg && i_pun_row_strobe
                                && pass_reg == CRP_LAST_PASS;
        end
    end

    // ****************************************************************
    // skip answer
    // ****************************************************************
    wire logic buf_empty = !buf_full_reg && !pun_busy_reg;
    wire logic skip_now  = (is_rrt && rdr_ready_reg)
                         | (is_fct && imminent)
                         | (is_eoft && !eof_reg)
                         | (is_pbt && buf_empty)
                         | (is_prt && pun_ready_reg);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_skip_valid <= 1'b0;
            o_skip       <= 1'b0;
        end else begin
            o_skip_valid <= is_test;
            o_skip       <= is_test && skip_now;
        end
    end

endmodule

// File: tb/crp_coupler_assertions.sv
`timescale 1ns/100ps
module crp_coupler_chk
    import crp_pkg::*;
(
    // clock, reset, instructions, punch faults
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic        i_instr_valid,
    input wire logic [23:0] i_instr,
    input wire logic        i_pun_magazine_empty,
    input wire logic        i_pun_stacker_full,
    // observed outputs
    input wire logic        o_skip_valid,
    input wire logic        o_skip,
    input wire logic        o_rdr_feed,
    input wire logic        o_ch_char_valid,
    input wire logic        o_ch_validity_err,
    input wire logic        o_ch_end_record,
    input wire logic        o_rdr_connected,
    input wire logic        o_pun_ready,
    input wire logic        o_pun_row_valid,
    input wire logic [3:0]  o_pun_row,
    input wire logic        o_pun_cycle_done
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    logic [23:0] op;
    logic        is_test;
    logic        is_read;
    assign op = i_instr & CRP_OP_MASK;
    assign is_test = i_instr_valid && (op inside {CRP_OP_RDR_READY_TEST, CRP_OP_FIRST_COL_TEST,
        CRP_OP_RDR_EOF_TEST, CRP_OP_PUN_BUF_TEST, CRP_OP_PUN_READY_TEST});
    assign is_read = i_instr_valid && (op inside {CRP_OP_READ_TEXT, CRP_OP_READ_RAW});
    AST_SKIP_ANSWER: assert property (is_test |=> o_skip_valid)
        else $error("test without skip answer");
    AST_PUN_READY_SKIP: assert property (is_test && op == CRP_OP_PUN_READY_TEST
        |=> o_skip == o_pun_ready) else $error("punch ready test wrong");
    AST_PUN_NOT_READY: assert property ((i_pun_magazine_empty || i_pun_stacker_full)
        |-> ##[1:2] !o_pun_ready) else $error("punch ready without cards or room");
    AST_ROW_RANGE: assert property (o_pun_row_valid |-> o_pun_row <= 4'hb)
        else $error("row out of range");
    AST_DONE_ROW9: assert property (o_pun_cycle_done |-> $past(o_pun_row) == 4'h0)
        else $error("cycle done before last row");
    AST_FEED_CAUSE: assert property (o_rdr_feed |-> $past(is_read))
        else $error("feed without read start");
    AST_FEED_QUIET: assert property (o_rdr_feed |=> !o_ch_char_valid [*8])
        else $error("character during feed");
    AST_ERR_WITH_CHAR: assert property (o_ch_validity_err |-> o_ch_char_valid)
        else $error("validity error alone");
    AST_EOR_DISC: assert property (o_ch_end_record |=> !o_rdr_connected)
        else $error("reader stays connected");
    cover property (o_pun_cycle_done);
    cover property (o_ch_validity_err);
    cover property (o_ch_end_record);
endmodule

// File: tb/crp_punch_mech.sv
`timescale 1ns/100ps
// punch mechanism: strobes each presented row a few cycles later
module crp_punch_mech (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_resetn,
    // row handshake
    input  wire logic i_row_valid,
    output logic      o_row_strobe
);
    logic [2:0] cnt_reg;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_reg      <= 3'h0;
            o_row_strobe <= 1'b0;
        end else begin
            o_row_strobe <= i_row_valid && cnt_reg == 3'h3;
            cnt_reg      <= !i_row_valid ? 3'h0 : (cnt_reg == 3'h4 ? cnt_reg : cnt_reg + 3'h1);
        end
    end
endmodule

// File: tb/crp_coupler_tb.sv
`timescale 1ns/100ps
module crp_coupler_tb;
    import crp_pkg::*;
    localparam int FEED = 200;
    logic i_clk, i_resetn, i_instr_valid, i_rdr_hopper_empty, i_rdr_stacker_full;
    logic i_rdr_start_btn, i_rdr_eof_switch, i_rdr_last_card, i_rdr_col_valid, i_rdr_col_ok;
    logic i_rdr_read_check, i_rdr_feed_check, i_ch_count_zero, i_pun_magazine_empty;
    logic i_pun_stacker_full, i_pun_start_btn, i_pun_row_strobe, i_ch_out_valid;
    logic o_skip_valid, o_skip, o_rdr_feed, o_ch_char_valid, o_ch_validity_err, o_ch_end_record;
    logic o_ch_count_zero_int, o_rdr_connected, o_pun_ready, o_pun_feed, o_pun_row_valid;
    logic o_pun_cycle_done;
    logic [23:0] i_instr;
    logic [11:0] i_rdr_col;
    logic [5:0]  i_ch_out_char, o_ch_char;
    logic [3:0]  o_pun_row;
    logic [79:0] o_pun_holes;
    int          err_count, n_checks;
    crp_coupler #(.FEED_CYC(FEED), .IMMINENT_CYC(20)) dut (.i_clk, .i_resetn, .i_instr_valid,
        .i_instr, .o_skip_valid, .o_skip, .i_rdr_hopper_empty, .i_rdr_stacker_full,
        .i_rdr_start_btn, .i_rdr_eof_switch, .i_rdr_last_card, .i_rdr_col_valid, .i_rdr_col,
        .i_rdr_col_ok, .i_rdr_read_check, .i_rdr_feed_check, .o_rdr_feed, .i_ch_count_zero,
        .o_ch_char_valid, .o_ch_char, .o_ch_validity_err, .o_ch_end_record, .o_ch_count_zero_int,
        .o_rdr_connected, .i_pun_magazine_empty, .i_pun_stacker_full, .i_pun_start_btn,
        .i_pun_row_strobe, .o_pun_ready, .o_pun_feed, .o_pun_row_valid, .o_pun_row, .o_pun_holes,
        .o_pun_cycle_done, .i_ch_out_valid, .i_ch_out_char);
    crp_punch_mech u_mech (.i_clk, .i_resetn, .i_row_valid(o_pun_row_valid),
        .o_row_strobe(i_pun_row_strobe));
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic close_out();
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        {i_instr_valid, i_rdr_col_valid} = 2'b00;
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic issue(input logic [23:0] op);
        i_rdr_col_valid = 1'b0;
        i_instr = op;
        i_instr_valid = 1'b1;
        @(posedge i_clk);
        #1;
    endtask
    task automatic test(input logic [23:0] op, input logic exp);
        issue(op);
        chk({o_skip_valid, o_skip}, {1'b1, exp});
    endtask
    function automatic logic sig(input int k);
        return k == 0 ? o_ch_char_valid : k == 1 ? o_pun_row_valid :
            k == 2 ? o_pun_cycle_done : o_ch_end_record;
    endfunction
    task automatic await(input int k, input int lim);
        for (int i = 0; i < lim && sig(k) !== 1'b1; i++) step(1);
        chk(sig(k), 1'b1);
    endtask
    task automatic col(input logic [11:0] c);
        i_instr_valid = 1'b0;
        i_rdr_col = c;
        i_rdr_col_valid = 1'b1;
        @(posedge i_clk);
        #1;
    endtask
    initial begin
        step(20000);
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end
    initial begin
        {i_resetn, i_instr, i_rdr_hopper_empty, i_rdr_stacker_full} = '0;
        {i_rdr_start_btn, i_rdr_eof_switch, i_rdr_last_card, i_rdr_col} = '0;
        {i_rdr_read_check, i_rdr_feed_check, i_ch_count_zero, i_pun_magazine_empty} = '0;
        {i_pun_stacker_full, i_pun_start_btn, i_ch_out_valid, i_ch_out_char} = '0;
        i_rdr_col_ok = 1'b1;
        step(20);
        i_resetn = 1'b1;
        step(1);
        test(CRP_OP_RDR_READY_TEST, 1'b0);
        test(CRP_OP_PUN_READY_TEST, 1'b0);
        {i_rdr_start_btn, i_pun_start_btn} = 2'h3;
        step(1);
        {i_rdr_start_btn, i_pun_start_btn} = 2'h0;
        step(2);
        test(CRP_OP_RDR_READY_TEST, 1'b1);
        test(CRP_OP_PUN_READY_TEST, 1'b1);
        test(CRP_OP_PUN_BUF_TEST, 1'b1);
        test(CRP_OP_RDR_EOF_TEST, 1'b1);
        issue(CRP_OP_READ_TEXT);
        chk(o_rdr_feed, 1'b1);
        test(CRP_OP_FIRST_COL_TEST, 1'b0);
        step(FEED - 15);
        test(CRP_OP_FIRST_COL_TEST, 1'b1);
        step(20);
        col(12'h900);
        await(0, 8);
        chk(o_ch_char, 6'h31);
        col(12'h003);
        await(0, 8);
        chk(o_ch_validity_err, 1'b1);
        issue(CRP_OP_SKIP_REST);
        i_rdr_read_check = 1'b1;
        step(1);
        i_rdr_read_check = 1'b0;
        await(3, 8);
        step(1);
        chk(o_rdr_connected, 1'b0);
        issue(CRP_OP_READ_RAW);
        chk(o_rdr_feed, 1'b1);
        step(FEED + 2);
        col(12'hfc1);
        chk({o_ch_char_valid, o_ch_char}, {1'b1, 6'h3f});
        step(1);
        chk({o_ch_char_valid, o_ch_char}, {1'b1, 6'h01});
        i_ch_count_zero = 1'b1;
        step(1);
        i_ch_count_zero = 1'b0;
        chk(o_ch_count_zero_int, 1'b1);
        {i_rdr_hopper_empty, i_rdr_eof_switch, i_rdr_last_card} = 3'h7;
        step(1);
        i_rdr_last_card = 1'b0;
        step(2);
        test(CRP_OP_RDR_EOF_TEST, 1'b0);
        test(CRP_OP_RDR_READY_TEST, 1'b0);
        i_rdr_hopper_empty = 1'b0;
        step(2);
        test(CRP_OP_RDR_EOF_TEST, 1'b1);
        test(CRP_OP_RDR_READY_TEST, 1'b0);
        for (int m = 0; m < 2; m++) begin
            for (int p = 0; p < 12; p++) begin
                issue(m ? CRP_OP_PUNCH_RAW : CRP_OP_PUNCH_TEXT);
                if (p == 0) chk(o_pun_feed, 1'b1);
                for (int c = 0; c < (m ? 160 : 80); c++) begin
                    i_ch_out_char = (c == 0) ? 6'h31 : 6'h00;
                    i_ch_out_valid = 1'b1;
                    step(1);
                    i_ch_out_valid = 1'b0;
                    step(1);
                    if (c == 40 && p == 0) test(CRP_OP_PUN_BUF_TEST, 1'b0);
                end
                await(1, 40);
                chk(o_pun_row, 80'(11 - p));
                // raw: 6'h31 as top half holes rows 12, 11 and 3
                chk(|o_pun_holes, m ? p inside {0, 1, 5} : p inside {0, 3});
                if (p == 11) await(2, 20);
                else step(8);
            end
        end
        i_pun_magazine_empty = 1'b1;
        step(2);
        test(CRP_OP_PUN_READY_TEST, 1'b0);
        close_out();
    end
endmodule
bind crp_coupler crp_coupler_chk u_chk (.i_clk, .i_resetn, .i_instr_valid, .i_instr,
    .i_pun_magazine_empty, .i_pun_stacker_full, .o_skip_valid, .o_skip, .o_rdr_feed,
    .o_ch_char_valid, .o_ch_validity_err, .o_ch_end_record, .o_rdr_connected, .o_pun_ready,
    .o_pun_row_valid, .o_pun_row, .o_pun_cycle_done);
